/* hdl/sfe_defines.svh */
// Constants of the serial flash front end: sizes, opcodes, status layout, timing.
// Assumes the including file uses them at the widths given here.
`ifndef SFE_DEFINES_SVH
`define SFE_DEFINES_SVH

// ------------------------------------------------------------
// Clock and timing
// ------------------------------------------------------------
`define SFE_CLK_MHZ 200
`define SFE_PROG_TIME_NS 2000000
`define SFE_PROG_CYC ((`SFE_PROG_TIME_NS * `SFE_CLK_MHZ) / 1000)

// ------------------------------------------------------------
// Array geometry
// ------------------------------------------------------------
`define SFE_ADDR_W 18
`define SFE_PAGE_BYTES 256
`define SFE_SECTOR_BYTES 4096
`define SFE_BLOCK_SMALL_BYTES 32768
`define SFE_BLOCK_LARGE_BYTES 65536
`define SFE_ERASED_BYTE 8'hff

// ------------------------------------------------------------
// Opcodes
// ------------------------------------------------------------
`define SFE_OP_WRITE_UNLOCK 8'h06
`define SFE_OP_WRITE_LOCK 8'h04
`define SFE_OP_READ_STATUS 8'h05
`define SFE_OP_WRITE_STATUS 8'h01
`define SFE_OP_READ 8'h03
`define SFE_OP_FAST_READ 8'h0b
`define SFE_OP_DUAL_READ 8'h3b
`define SFE_OP_PAGE_PROG 8'h02
`define SFE_OP_SECTOR_ERASE 8'h20
`define SFE_OP_BLOCK_ERASE 8'hd8
`define SFE_OP_CHIP_ERASE 8'hc7

// ------------------------------------------------------------
// Status byte layout
// ------------------------------------------------------------
`define SFE_ST_SRWD 7
`define SFE_ST_BP_HI 4
`define SFE_ST_BP_LO 2

`endif

/* hdl/sfe_front_end.sv */
// Serial flash front end: command engine, status, protection and array.
// Assumes an SPI master on the pins and a free-running system clock.
`include "sfe_defines.svh"

module sfe_front_end
  import sfe_pkg::*;
#(
  parameter int ADDR_W = `SFE_ADDR_W,
  parameter int BLOCK_BYTES = `SFE_BLOCK_LARGE_BYTES,
  parameter int PROG_CYCLES = `SFE_PROG_CYC
)
(
  input wire logic clock,
  input wire logic clock_enable,
  input wire logic rstn,
  input wire logic serial_clock,
  input wire logic chip_enable_n,
  input wire logic pause_n,
  input wire logic write_protect_n,
  input wire logic serial_data_in_out_i,
  output logic serial_data_in_out_o,
  output logic serial_data_in_out_oe,
  output logic serial_out_o,
  output logic serial_out_oe,
  output logic program_busy_flag,
  output logic write_latch_flag,
  output logic [2:0] protect_range,
  output logic standby,
  output logic rx_ready
);

  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int MEM_BYTES = 1 << ADDR_W;
  localparam logic [ADDR_W-1:0] PAGE_MASK = ADDR_W'(`SFE_PAGE_BYTES - 1);
  localparam logic [ADDR_W-1:0] SECTOR_MASK = ADDR_W'(`SFE_SECTOR_BYTES - 1);
  localparam logic [ADDR_W-1:0] BLOCK_MASK = ADDR_W'(BLOCK_BYTES - 1);

  typedef struct packed {
    logic sel1;
    logic sel2;
    logic sel3;
    logic tog1;
    logic tog2;
    logic tog3;
    logic wp1;
    logic wp2;
    logic [1:0][7:0] fifo;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] fill;
    sfe_state_t state;
    sfe_cmd_t cmd;
    logic [1:0] addr_cnt;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdat;
    logic stall;
    logic [7:0] tx;
    logic tx_en;
    logic dual;
    sfe_pend_t pend;
    logic frame_end;
    logic wen;
    logic [2:0] bp;
    logic srwd;
    logic erasing;
    logic [ADDR_W-1:0] erase_addr;
    logic [ADDR_W-1:0] erase_last;
    logic [31:0] prog_cnt;
    logic busy;
  } sfe_core_t;

  sfe_core_t r;
  sfe_core_t next_r;
  logic [7:0] mem [0:MEM_BYTES-1];
  logic mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic push;
  logic pop;
  logic [7:0] byte_in;
  logic [ADDR_W-1:0] addr_new;
  logic [7:0] rd_cur;
  logic [7:0] rd_new;
  logic [7:0] status;
  logic rst_s1;
  logic rst_s2;

  sfe_link_if lnk ();

  // ------------------------------------------------------------
  // Protection decode
  // ------------------------------------------------------------
  // Protected area grows down from the top of the array
  function automatic logic is_prot(input logic [ADDR_W-1:0] a, input logic [2:0] bp, input logic wpn);
    logic [ADDR_W:0] lim;
    lim = (ADDR_W+1)'(MEM_BYTES) - ((ADDR_W+1)'(MEM_BYTES) >> (3'd7 - bp));
    is_prot = !wpn && (bp != 3'd0) && ({1'b0, a} >= lim);
  endfunction

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // ------------------------------------------------------------
  // Link side
  // ------------------------------------------------------------
  sfe_link u_link (
    .serial_clock(serial_clock),
    .chip_enable_n(chip_enable_n),
    .pause_n(pause_n),
    .serial_data_in_out_i(serial_data_in_out_i),
    .serial_data_in_out_o(serial_data_in_out_o),
    .serial_data_in_out_oe(serial_data_in_out_oe),
    .serial_out_o(serial_out_o),
    .serial_out_oe(serial_out_oe),
    .lnk(lnk.link)
  );

  assign lnk.tx_byte = r.tx;
  assign lnk.tx_dual = r.dual;
  assign lnk.tx_en = r.tx_en;
  assign lnk.rst_n = rst_s2;

  // ------------------------------------------------------------
  // Array reads
  // ------------------------------------------------------------
  assign byte_in = r.fifo[r.rd_ptr];
  assign addr_new = ADDR_W'({r.addr, byte_in});
  assign rd_cur = mem[r.addr];
  assign rd_new = mem[addr_new];
  assign status = {r.srwd, 2'b00, r.bp, r.wen, r.busy};
  assign rx_ready = (r.fill != 2'd2);

  // ------------------------------------------------------------
  // Command engine
  // ------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    mem_we = 1'b0;
    mem_wa = r.erase_addr;
    mem_wd = `SFE_ERASED_BYTE;
    next_r.sel1 = !chip_enable_n;
    next_r.sel2 = r.sel1;
    next_r.sel3 = r.sel2;
    next_r.tog1 = lnk.rx_toggle;
    next_r.tog2 = r.tog1;
    next_r.tog3 = r.tog2;
    next_r.wp1 = write_protect_n;
    next_r.wp2 = r.wp1;

    // Two-entry buffer; the engine stalls for each program write
    push = (r.tog2 ^ r.tog3) && rx_ready;
    pop = (r.fill != 2'd0) && !r.stall;
    if (push)
    begin
      next_r.fifo[r.wr_ptr] = lnk.rx_byte;
      next_r.wr_ptr = !r.wr_ptr;
    end
    if (pop)
      next_r.rd_ptr = !r.rd_ptr;
    next_r.fill = r.fill + {1'b0, push} - {1'b0, pop};

    if (!r.sel2 && r.sel3)
      next_r.frame_end = 1'b1;
    if (r.prog_cnt != 32'd0)
      next_r.prog_cnt = r.prog_cnt - 32'd1;

    // One byte per cycle, so a chip erase takes one cycle for each byte of the array
    if (r.erasing)
    begin
      mem_we = 1'b1;
      next_r.erase_addr = r.erase_addr + 1'b1;
      if (r.erase_addr == r.erase_last)
        next_r.erasing = 1'b0;
    end

    // Program can only clear bits; address wraps inside the page
    if (r.stall)
    begin
      next_r.stall = 1'b0;
      if (!is_prot(r.addr, r.bp, r.wp2))
      begin
        mem_we = 1'b1;
        mem_wa = r.addr;
        mem_wd = rd_cur & r.wdat;
      end
      next_r.addr = (r.addr & ~PAGE_MASK) | ((r.addr + 1'b1) & PAGE_MASK);
    end

    if (pop)
    begin
      unique case (r.state)
        ST_IDLE:
        begin
          next_r.state = ST_IGNORE;
          next_r.addr_cnt = 2'd0;
          case (byte_in)
            `SFE_OP_WRITE_UNLOCK:
              next_r.wen = r.busy ? r.wen : 1'b1;
            `SFE_OP_WRITE_LOCK:
              next_r.wen = r.busy ? r.wen : 1'b0;
            `SFE_OP_READ_STATUS:
            begin
              next_r.state = ST_STAT;
              next_r.tx_en = 1'b1;
            end
            `SFE_OP_WRITE_STATUS:
              if (r.wen && !r.busy && !(r.srwd && !r.wp2))
                next_r.state = ST_WSR;
            `SFE_OP_READ:
            begin
              next_r.cmd = CMD_READ;
              next_r.state = r.busy ? ST_IGNORE : ST_ADDR;
            end
            `SFE_OP_FAST_READ:
            begin
              next_r.cmd = CMD_FAST;
              next_r.state = r.busy ? ST_IGNORE : ST_ADDR;
            end
            `SFE_OP_DUAL_READ:
            begin
              next_r.cmd = CMD_DUAL;
              next_r.state = r.busy ? ST_IGNORE : ST_ADDR;
            end
            `SFE_OP_PAGE_PROG:
            begin
              next_r.cmd = CMD_PROG;
              next_r.state = (r.wen && !r.busy) ? ST_ADDR : ST_IGNORE;
            end
            `SFE_OP_SECTOR_ERASE:
            begin
              next_r.cmd = CMD_SECTOR;
              next_r.state = (r.wen && !r.busy) ? ST_ADDR : ST_IGNORE;
            end
            `SFE_OP_BLOCK_ERASE:
            begin
              next_r.cmd = CMD_BLOCK;
              next_r.state = (r.wen && !r.busy) ? ST_ADDR : ST_IGNORE;
            end
            `SFE_OP_CHIP_ERASE:
              if (r.wen && !r.busy)
              begin
                next_r.pend = PEND_ERASE;
                next_r.erase_addr = '0;
                next_r.erase_last = '1;
              end
            default:
              next_r.cmd = CMD_OTHER;
          endcase
        end
        ST_ADDR:
        begin
          next_r.addr = addr_new;
          next_r.addr_cnt = r.addr_cnt + 2'd1;
          if (r.addr_cnt == 2'd2)
          begin
            next_r.state = ST_IGNORE;
            case (r.cmd)
              CMD_READ:
              begin
                next_r.state = ST_READ;
                next_r.tx = rd_new;
                next_r.tx_en = 1'b1;
                next_r.addr = addr_new + 1'b1;
              end
              CMD_FAST, CMD_DUAL:
                next_r.state = ST_DUMMY;
              CMD_PROG:
                next_r.state = ST_PROG;
              CMD_SECTOR:
              begin
                next_r.pend = PEND_ERASE;
                next_r.erase_addr = addr_new & ~SECTOR_MASK;
                next_r.erase_last = addr_new | SECTOR_MASK;
              end
              CMD_BLOCK:
              begin
                next_r.pend = PEND_ERASE;
                next_r.erase_addr = addr_new & ~BLOCK_MASK;
                next_r.erase_last = addr_new | BLOCK_MASK;
              end
              default:
                next_r.state = ST_IGNORE;
            endcase
          end
        end
        ST_DUMMY:
        begin
          next_r.state = ST_READ;
          next_r.tx = rd_cur;
          next_r.tx_en = 1'b1;
          next_r.dual = (r.cmd == CMD_DUAL);
          next_r.addr = r.addr + 1'b1;
        end
        ST_READ:
        begin
          next_r.tx = rd_cur;
          next_r.addr = r.addr + 1'b1;
        end
        ST_PROG:
        begin
          next_r.wdat = byte_in;
          next_r.stall = 1'b1;
          next_r.pend = PEND_PROG;
        end
        ST_WSR:
        begin
          next_r.wdat = byte_in;
          next_r.pend = PEND_WSR;
          next_r.state = ST_IGNORE;
        end
        ST_STAT, ST_IGNORE:
          next_r.state = r.state;
      endcase
    end

    if (next_r.state == ST_STAT)
      next_r.tx = status;

    // Erase and status writes start once chip enable rises; program bytes reach the array as they arrive
    if (r.frame_end && r.fill == 2'd0 && !push && !r.stall)
    begin
      next_r.frame_end = !r.sel2 && r.sel3;
      next_r.state = ST_IDLE;
      next_r.tx_en = 1'b0;
      next_r.dual = 1'b0;
      next_r.pend = PEND_NONE;
      unique case (r.pend)
        PEND_NONE:
          next_r.pend = PEND_NONE;
        PEND_PROG:
        begin
          next_r.prog_cnt = 32'(PROG_CYCLES);
          next_r.wen = 1'b0;
        end
        PEND_ERASE:
        begin
          next_r.erasing = !is_prot(r.erase_last, r.bp, r.wp2);
          next_r.wen = 1'b0;
        end
        PEND_WSR:
        begin
          next_r.srwd = r.wdat[`SFE_ST_SRWD];
          next_r.bp = r.wdat[`SFE_ST_BP_HI:`SFE_ST_BP_LO];
          next_r.wen = 1'b0;
        end
      endcase
    end

    next_r.busy = next_r.erasing || (next_r.prog_cnt != 32'd0);
  end

  // ------------------------------------------------------------
  // State and array
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_s2)
  begin
    if (!rst_s2)
      r <= '0;
    else if (clock_enable)
      r <= next_r;
  end

  // Array has no reset, as flash contents survive it
  always_ff @(posedge clock)
  begin
    if (clock_enable && mem_we)
      mem[mem_wa] <= mem_wd;
  end

  assign program_busy_flag = r.busy;
  assign write_latch_flag = r.wen;
  assign protect_range = r.bp;
  assign standby = !r.sel2;

endmodule

/* hdl/sfe_link.sv */
// Serial-clock side of the front end: shifts bytes in and out on the pins.
// Assumes nothing of the serial clock while chip enable is high; the shifters stay cleared then.
module sfe_link
  import sfe_pkg::*;
(
  input wire logic serial_clock,
  input wire logic chip_enable_n,
  input wire logic pause_n,
  input wire logic serial_data_in_out_i,
  output logic serial_data_in_out_o,
  output logic serial_data_in_out_oe,
  output logic serial_out_o,
  output logic serial_out_oe,
  sfe_link_if.link lnk
);

  sfe_rise_t r;
  sfe_rise_t next_r;
  sfe_rx_t x;
  sfe_rx_t next_x;
  sfe_fall_t f;
  sfe_fall_t next_f;
  logic frame_clr;

  // ------------------------------------------------------------
  // Rising edge: sample input
  // ------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_x = x;
    // Pause freezes the count instead of clearing it
    if (pause_n)
    begin
      next_r.shift = {r.shift[6:0], serial_data_in_out_i};
      next_r.cnt = r.cnt + 3'd1;
      // Dual output makes a byte four clocks long
      if (r.cnt == (f.dual ? 3'd3 : 3'd7))
      begin
        next_r.cnt = 3'd0;
        next_x.rx_byte = {r.shift[6:0], serial_data_in_out_i};
        next_x.rx_toggle = !x.rx_toggle;
      end
    end
  end

  // ------------------------------------------------------------
  // Falling edge: launch output
  // ------------------------------------------------------------
  always_comb
  begin
    logic [7:0] src;
    logic dual;
    src = f.shift;
    dual = f.dual;
    next_f = f;
    if (pause_n)
    begin
      // Tx byte is sampled at the byte boundary, well after the core wrote it
      if (r.cnt == 3'd0)
      begin
        src = lnk.tx_byte;
        dual = lnk.tx_dual;
        next_f.en = lnk.tx_en;
        next_f.dual = lnk.tx_dual;
      end
      next_f.out_hi = src[7];
      next_f.out_lo = src[6];
      next_f.shift = dual ? {src[5:0], 2'b00} : {src[6:0], 1'b0};
    end
  end

  // Deselect holds the shifters cleared, so no bit is captured
  assign frame_clr = chip_enable_n || !lnk.rst_n;

  // Posedge sampling and negedge launch serve mode 0 and mode 3 alike
  always_ff @(posedge serial_clock or posedge frame_clr)
  begin
    if (frame_clr)
      r <= '0;
    else
      r <= next_r;
  end

  // Toggle survives deselect so the core never sees a false byte
  always_ff @(posedge serial_clock or negedge lnk.rst_n)
  begin
    if (!lnk.rst_n)
      x <= '0;
    else
      x <= next_x;
  end

  always_ff @(negedge serial_clock or posedge frame_clr)
  begin
    if (frame_clr)
      f <= '0;
    else
      f <= next_f;
  end

  assign lnk.rx_byte = x.rx_byte;
  assign lnk.rx_toggle = x.rx_toggle;
  assign serial_out_o = f.out_hi;
  assign serial_data_in_out_o = f.out_lo;
  assign serial_out_oe = !chip_enable_n && pause_n && f.en;
  assign serial_data_in_out_oe = !chip_enable_n && pause_n && f.en && f.dual;

endmodule

/* hdl/sfe_link_if.sv */
// Carrier between the core clock domain and the serial clock domain.
// Assumes tx fields stay steady for a whole byte time once written.
interface sfe_link_if;
  logic [7:0] rx_byte;
  logic rx_toggle;
  logic [7:0] tx_byte;
  logic tx_dual;
  logic tx_en;
  logic rst_n;

  modport link (output rx_byte, output rx_toggle, input tx_byte, input tx_dual, input tx_en, input rst_n);
  modport core (input rx_byte, input rx_toggle, output tx_byte, output tx_dual, output tx_en, output rst_n);
endinterface

/* hdl/sfe_pkg.sv */
// Types shared by the front end core and its link-side shifter.
// Assumes nothing beyond a SystemVerilog compiler.
package sfe_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_DUMMY = 3'b010,
    ST_READ = 3'b011,
    ST_PROG = 3'b100,
    ST_STAT = 3'b101,
    ST_WSR = 3'b110,
    ST_IGNORE = 3'b111
  } sfe_state_t;

  typedef enum logic [2:0] {
    CMD_READ = 3'b000,
    CMD_FAST = 3'b001,
    CMD_DUAL = 3'b010,
    CMD_PROG = 3'b011,
    CMD_SECTOR = 3'b100,
    CMD_BLOCK = 3'b101,
    CMD_OTHER = 3'b110
  } sfe_cmd_t;

  typedef enum logic [1:0] {
    PEND_NONE = 2'b00,
    PEND_PROG = 2'b01,
    PEND_ERASE = 2'b10,
    PEND_WSR = 2'b11
  } sfe_pend_t;

  typedef struct packed {
    logic [7:0] shift;
    logic [2:0] cnt;
  } sfe_rise_t;

  typedef struct packed {
    logic [7:0] rx_byte;
    logic rx_toggle;
  } sfe_rx_t;

  typedef struct packed {
    logic [7:0] shift;
    logic dual;
    logic en;
    logic out_hi;
    logic out_lo;
  } sfe_fall_t;

endpackage

/* tb/sfe_checker.sv */
// Concurrent checks on the pins and flags of the front end top module.
// Assumes binding to sfe_front_end; all checks run on the system clock.
module sfe_checker #(
  parameter int ADDR_W = 18,
  parameter int PROG_CYCLES = 400000
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic chip_enable_n,
  input wire logic pause_n,
  input wire logic serial_out_oe,
  input wire logic serial_data_in_out_oe,
  input wire logic program_busy_flag,
  input wire logic write_latch_flag,
  input wire logic [2:0] protect_range,
  input wire logic standby
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  localparam int BUSY_MAX = ((1 << ADDR_W) > PROG_CYCLES ? (1 << ADDR_W) : PROG_CYCLES) + 8;
  logic [31:0] busy_run;
  // Counter instead of a long repetition, which the tools would unroll
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      busy_run <= 32'h0;
    else if (program_busy_flag)
      busy_run <= busy_run + 32'h1;
    else
      busy_run <= 32'h0;
  sequence sel_start;
    $fell(chip_enable_n) ##1 !chip_enable_n [*3];
  endsequence
  sequence desel_run;
    chip_enable_n [*4];
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  desel_hiz_a: assert property (chip_enable_n |-> !serial_out_oe && !serial_data_in_out_oe)
    else $error("output driven while deselected");
  pause_hiz_a: assert property (!pause_n |-> !serial_out_oe && !serial_data_in_out_oe)
    else $error("output driven while paused");
  dual_pair_a: assert property (serial_data_in_out_oe |-> serial_out_oe)
    else $error("second data line driven alone");
  standby_enter_a: assert property (desel_run |-> standby)
    else $error("no standby while deselected");
  select_wake_a: assert property (sel_start |-> !standby)
    else $error("still in standby while selected");
  busy_after_frame_a: assert property ($rose(program_busy_flag) |-> chip_enable_n)
    else $error("busy rose inside a frame");
  latch_spent_a: assert property ($rose(program_busy_flag) |-> ##[0:2] !write_latch_flag)
    else $error("write latch kept after a write started");
  busy_hold_a: assert property ($rose(program_busy_flag) |=> program_busy_flag [*8])
    else $error("busy dropped too early");
  protect_frame_a: assert property ($changed(protect_range) |-> chip_enable_n)
    else $error("protect bits changed inside a frame");
  busy_bounded_a: assert property (busy_run <= BUSY_MAX)
    else $error("busy lasted too long");
  busy_seen_c: cover property ($rose(program_busy_flag));
endmodule

/* tb/sfe_master_model.sv */
// Behavioural SPI master on the serial pins, mode 0 or mode 3.
// Assumes the bench calls one task at a time from one process.
module sfe_master_model (
  output logic serial_clock,
  output logic chip_enable_n,
  output logic pause_n,
  output logic serial_data_in_out_i,
  input wire logic serial_data_in_out_o,
  input wire logic serial_data_in_out_oe,
  input wire logic serial_out_o,
  input wire logic serial_out_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Pin state
  // ----------------------------------------
  logic mode3 = 1'b0;
  logic mosi = 1'b0;
  logic mosi_en = 1'b0;
  logic [7:0] rd_q [$];
  // Released line shows the inverse of its last bit, never a stale copy
  assign serial_data_in_out_i = serial_data_in_out_oe ? serial_data_in_out_o : (mosi_en ? mosi : !mosi);
  initial
  begin
    serial_clock = 1'b0;
    chip_enable_n = 1'b1;
    pause_n = 1'b1;
  end
  task automatic xfer(input logic [7:0] tx, input bit dual, input bit hold, output logic [7:0] rx);
    logic so;
    rx = 8'h00;
    for (int i = 0; i < (dual ? 4 : 8); i++)
    begin
      serial_clock = 1'b0;
      if (hold && i == 3)
      begin
        pause_n = 1'b0;
        repeat (3)
        begin
          #3 serial_clock = 1'b1;
          mosi = !mosi;
          #3 serial_clock = 1'b0;
        end
        pause_n = 1'b1;
      end
      mosi = tx[7 - i];
      mosi_en = !dual;
      #3;
      so = serial_out_oe ? serial_out_o : 1'bx;
      rx = dual ? {rx[5:0], so, serial_data_in_out_i} : {rx[6:0], so};
      serial_clock = 1'b1;
      #3;
    end
    // Clock parked high so the core has time to load the next byte
    #40;
  endtask
  task automatic frame(input logic [7:0] q [$], input int nrd, input bit dual, input int hold_at);
    logic [7:0] b;
    rd_q = {};
    serial_clock = mode3;
    #5 chip_enable_n = 1'b0;
    #10;
    foreach (q[i]) xfer(q[i], 1'b0, i == hold_at, b);
    repeat (nrd)
    begin
      xfer(8'($urandom), dual, 1'b0, b);
      rd_q.push_back(b);
    end
    serial_clock = mode3;
    #10 chip_enable_n = 1'b1;
    mosi_en = 1'b0;
    #60;
  endtask
  task automatic noise();
    mosi_en = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      serial_clock = 1'b0;
      mosi = (i % 8 == 5) || (i % 8 == 6);
      #3 serial_clock = 1'b1;
      #3;
    end
    serial_clock = mode3;
    mosi_en = 1'b0;
  endtask
endmodule

/* tb/test_spi_flash_serial_front_end.sv */
// Self-checking bench of the serial flash front end.
// Assumes the master model and checker are compiled with the design.
module test_spi_flash_serial_front_end;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Setup
  // ----------------------------------------
  localparam int AW = 14;
  localparam int BLK = 8192;
  localparam int PROG = 50;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic clock_enable = 1'b1;
  logic write_protect_n = 1'b0;
  logic serial_clock, chip_enable_n, pause_n, dio_i, dio_o, dio_oe, so_o, so_oe;
  logic busy, wen, standby, rx_ready;
  logic [2:0] protect_range;
  logic [2:0] bp = 3'h0;
  logic [7:0] mem [int];
  int failures = 0;
  int checked = 0;
  int run_len = 0;
  int last_len = 0;
  always #2.5 clock = !clock;
  sfe_front_end #(.ADDR_W(AW), .BLOCK_BYTES(BLK), .PROG_CYCLES(PROG)) DUT (
    .clock(clock), .clock_enable(clock_enable), .rstn(rstn), .serial_clock(serial_clock),
    .chip_enable_n(chip_enable_n), .pause_n(pause_n), .write_protect_n(write_protect_n),
    .serial_data_in_out_i(dio_i), .serial_data_in_out_o(dio_o), .serial_data_in_out_oe(dio_oe),
    .serial_out_o(so_o), .serial_out_oe(so_oe), .program_busy_flag(busy), .write_latch_flag(wen),
    .protect_range(protect_range), .standby(standby), .rx_ready(rx_ready));
  sfe_master_model u (.serial_clock(serial_clock), .chip_enable_n(chip_enable_n), .pause_n(pause_n),
    .serial_data_in_out_i(dio_i), .serial_data_in_out_o(dio_o), .serial_data_in_out_oe(dio_oe),
    .serial_out_o(so_o), .serial_out_oe(so_oe));
  always @(posedge clock)
    if (busy === 1'b1)
      run_len <= run_len + 1;
    else if (run_len != 0)
    begin
      last_len <= run_len;
      run_len <= 0;
    end
  function automatic bit guarded(input int a);
    return write_protect_n === 1'b0 && bp != 3'h0 && a >= (1 << AW) - ((1 << AW) >> (7 - bp));
  endfunction
  function automatic logic [7:0] expect_at(input int a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_count(input int got, input int exp);
    checked++;
    if (got != exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_op(input logic [7:0] q [$], input int hold_at);
    int n;
    n = 0;
    u.frame('{8'h06}, 0, 1'b0, -1);
    u.frame(q, 0, 1'b0, hold_at);
    while (busy !== 1'b0 && n < 20000)
    begin
      @(posedge clock);
      n++;
    end
    @(posedge clock);
    #1;
  endtask
  task automatic status_check(input logic [7:0] exp);
    u.frame('{8'h05}, 1, 1'b0, -1);
    check_byte(u.rd_q[0], exp);
    check_byte({7'h00, rx_ready}, 8'h01);
  endtask
  task automatic prog_page(input int a, input int n, input int hold_at);
    logic [7:0] q [$];
    logic [7:0] d;
    int w;
    q = '{8'h02, a[23:16], a[15:8], a[7:0]};
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom);
      w = (a & 32'h7fffff00) | ((a + i) & 32'hff);
      q.push_back(d);
      if (!guarded(w)) mem[w] = expect_at(w) & d;
    end
    wr_op(q, hold_at);
  endtask
  task automatic read_check(input logic [7:0] op, input int a, input int n);
    u.frame('{op, a[23:16], a[15:8], a[7:0], 8'h00}, n, op == 8'h3b, -1);
    for (int i = 0; i < n; i++)
      check_byte(u.rd_q[i], expect_at(a + i));
  endtask
  task automatic erase(input logic [7:0] op, input int size);
    int base;
    base = $urandom_range((1 << AW) / size - 1, 1) * size;
    prog_page(base - 1, 1, -1);
    prog_page(base, 1, -1);
    wr_op('{op, base[23:16], base[15:8], base[7:0]}, -1);
    if (!guarded(base + size - 1))
    begin
      for (int i = base; i < base + size; i++) mem.delete(i);
      check_count(last_len, size);
    end
    read_check(8'h0b, base - 1, 2);
  endtask
  task automatic wrap_up();
    if (failures == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    #480000;
    failures++;
    wrap_up();
  end
  initial
  begin
    int a;
    int n;
    void'($urandom(32'ha6a96026));
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    status_check(8'h00);
    u.noise();
    status_check(8'h00);
    wr_op('{8'hc7}, -1);
    check_count(last_len, 1 << AW);
    u.frame('{8'h06}, 0, 1'b0, -1);
    status_check(8'h02);
    u.frame('{8'h04}, 0, 1'b0, -1);
    u.frame('{8'h02, 8'h00, 8'h01, 8'h00, 8'h5a}, 0, 1'b0, -1);
    read_check(8'h0b, 32'h100, 1);
    for (int k = 0; k < 8; k++)
    begin
      u.mode3 = k[0];
      a = $urandom_range((1 << AW) - 8, 0);
      n = $urandom_range(4, 1);
      if (k < 2) a[7:0] = 8'hfe;
      prog_page(a, n, k == 3 ? 4 : -1);
      check_count(last_len, PROG);
      read_check(k[1] ? 8'h3b : 8'h0b, a, 2);
      read_check(8'h0b, a & 32'h7fffff00, 2);
    end
    for (int b = 1; b < 8; b++)
    begin
      bp = 3'(b);
      wr_op('{8'h01, {3'h0, bp, 2'h0}}, -1);
      check_byte({5'h00, protect_range}, {5'h00, bp});
      status_check({3'h0, bp, 2'h0});
      erase(8'h20, 4096);
    end
    @(posedge clock) write_protect_n <= 1'b1;
    @(posedge clock);
    erase(8'hd8, BLK);
    wrap_up();
  end
endmodule
bind sfe_front_end sfe_checker #(.ADDR_W(ADDR_W), .PROG_CYCLES(PROG_CYCLES)) chk (
  .clock(clock), .rstn(rstn), .chip_enable_n(chip_enable_n), .pause_n(pause_n),
  .serial_out_oe(serial_out_oe), .serial_data_in_out_oe(serial_data_in_out_oe),
  .program_busy_flag(program_busy_flag), .write_latch_flag(write_latch_flag),
  .protect_range(protect_range), .standby(standby));
